// ===== logic/tmr2_map.svh
// register offsets, field positions and reset values of the timer two control block
`ifndef TMR2_MAP_SVH
`define TMR2_MAP_SVH
`define TMR2_OFF_SER_DATA  12'h264
`define TMR2_OFF_RELOAD    12'h268
`define TMR2_OFF_SLV_ADDR  12'h2a4
`define TMR2_OFF_SLV_MASK  12'h2e4
`define TMR2_OFF_CTRL      12'h320
`define TMR2_OFF_IRQ_STAT  12'h400
`define TMR2_OFF_IRQ_MASK  12'h404
`define TMR2_OFF_CLK_STAT  12'h408
`define TMR2_IDX_SER_DATA  8'h99
`define TMR2_IDX_RELOAD    8'h9a
`define TMR2_IDX_SLV_ADDR  8'ha9
`define TMR2_IDX_SLV_MASK  8'hb9
`define TMR2_IDX_CTRL      8'hc8
`define TMR2_BIT_OVF       7
`define TMR2_BIT_EXT       6
`define TMR2_BIT_RXSEL     5
`define TMR2_BIT_TXSEL     4
`define TMR2_RST_CTRL      8'h00
`define TMR2_RST_BYTE      8'h00
`define TMR2_IRQ_OVF       0
`define TMR2_IRQ_EXT       1
`endif

// ===== logic/tmr2_pkg.sv
// types of the timer two control block
package tmr2_pkg;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] ser_data;
		logic [7:0] reload;
		logic [7:0] slv_addr;
		logic [7:0] slv_mask;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic       ovf_evt;
		logic       ext_evt;
	} tmr2_state_t;

	typedef struct packed {
		logic rx_tick;
		logic tx_tick;
	} tmr2_baud_t;

	typedef struct packed {
		logic [7:0] bit_set;
		logic [7:0] bit_clr;
	} tmr2_bitop_t;
endpackage : tmr2_pkg

// ===== logic/tmr2_ctrl.sv
// timer two flags, interrupt request and uart bit clock selection
`timescale 1ns/1ps
`include "tmr2_map.svh"

module tmr2_ctrl (
	// clock, reset, enable
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_ce,
	// apb slave
	input  wire logic               i_psel,
	input  wire logic               i_penable,
	input  wire logic               i_pwrite,
	input  wire logic [11:0]        i_paddr,
	input  wire logic [31:0]        i_pwdata,
	output logic                    o_pready,
	output logic      [31:0]        o_prdata,
	output logic                    o_pslverr,
	// bit-addressed access to the control register
	input  wire tmr2_pkg::tmr2_bitop_t i_ctrl_bitop,
	// timer events (same clock domain)
	input  wire logic               i_timer_ovf,
	input  wire logic               i_ext_event,
	input  wire logic               i_other_timer_ovf,
	input  wire logic               i_timer_irq_en,
	// uart side
	output tmr2_pkg::tmr2_baud_t    o_baud,
	output logic      [7:0]         o_ctrl,
	output logic      [7:0]         o_ser_data,
	output logic      [7:0]         o_reload,
	output logic      [7:0]         o_slv_addr,
	output logic      [7:0]         o_slv_mask,
	// interrupts
	output logic                    o_timer_irq,
	output logic                    o_irq
);
	import tmr2_pkg::*;

	tmr2_state_t st_reg;
	tmr2_state_t st_next;
	logic        access;
	logic        wr;
	logic [7:0]  wb;

	assign access    = i_psel & i_penable;
	assign wr        = access & i_pwrite & i_ce;
	assign wb        = i_pwdata[7:0];
	assign o_pready  = 1'b1;

	always_comb begin
		o_pslverr = 1'b0;
		o_prdata  = 32'h0000_0000;
		case (i_paddr)
			`TMR2_OFF_SER_DATA: o_prdata[7:0] = st_reg.ser_data;
			`TMR2_OFF_RELOAD:   o_prdata[7:0] = st_reg.reload;
			`TMR2_OFF_SLV_ADDR: o_prdata[7:0] = st_reg.slv_addr;
			`TMR2_OFF_SLV_MASK: o_prdata[7:0] = st_reg.slv_mask;
			`TMR2_OFF_CTRL:     o_prdata[7:0] = st_reg.ctrl;
			`TMR2_OFF_IRQ_STAT: o_prdata[1:0] = st_reg.irq_stat;
			`TMR2_OFF_IRQ_MASK: o_prdata[1:0] = st_reg.irq_mask;
			`TMR2_OFF_CLK_STAT: o_prdata[1:0] = {o_baud.tx_tick, o_baud.rx_tick};
			default:            o_pslverr     = access;
		endcase
	end

	always_comb begin
		logic ovf_hit;
		logic ext_hit;
		ovf_hit = 1'b0;
		ext_hit = 1'b0;
		st_next = st_reg;
		st_next.ctrl = (st_reg.ctrl | i_ctrl_bitop.bit_set) & ~i_ctrl_bitop.bit_clr;
		if (wr) begin
			case (i_paddr)
				`TMR2_OFF_SER_DATA: st_next.ser_data = wb;
				`TMR2_OFF_RELOAD:   st_next.reload   = wb;
				`TMR2_OFF_SLV_ADDR: st_next.slv_addr = wb;
				`TMR2_OFF_SLV_MASK: st_next.slv_mask = wb;
				`TMR2_OFF_CTRL:     st_next.ctrl     = wb;
				`TMR2_OFF_IRQ_MASK: st_next.irq_mask = wb[1:0];
				`TMR2_OFF_IRQ_STAT: st_next.irq_stat = st_reg.irq_stat & ~wb[1:0];
				default: ;
			endcase
		end
		// overflow flag only when timer not used as a bit clock
		ovf_hit = i_timer_ovf & ~st_reg.ctrl[`TMR2_BIT_RXSEL] & ~st_reg.ctrl[`TMR2_BIT_TXSEL];
		ext_hit = i_ext_event;
		// set by hardware and by software writes or bit_set, hardware set wins over software clear
		if (ovf_hit) begin
			st_next.ctrl[`TMR2_BIT_OVF]    = 1'b1;
			st_next.irq_stat[`TMR2_IRQ_OVF] = 1'b1;
		end
		if (ext_hit) begin
			st_next.ctrl[`TMR2_BIT_EXT]    = 1'b1;
			st_next.irq_stat[`TMR2_IRQ_EXT] = 1'b1;
		end
		st_next.ovf_evt = i_timer_ovf;
		st_next.ext_evt = i_ext_event;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_reg       <= '0;
			st_reg.ctrl  <= `TMR2_RST_CTRL;
			st_reg.reload   <= `TMR2_RST_BYTE;
			st_reg.slv_addr <= `TMR2_RST_BYTE;
			st_reg.slv_mask <= `TMR2_RST_BYTE;
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

	assign o_baud = '{
		rx_tick: st_reg.ctrl[`TMR2_BIT_RXSEL] ? i_timer_ovf : i_other_timer_ovf,
		tx_tick: st_reg.ctrl[`TMR2_BIT_TXSEL] ? i_timer_ovf : i_other_timer_ovf
	};

	// timer interrupt request from either flag
	assign o_timer_irq = i_timer_irq_en &
		(st_reg.ctrl[`TMR2_BIT_EXT] | st_reg.ctrl[`TMR2_BIT_OVF]);
	assign o_irq       = |(st_reg.irq_stat & st_reg.irq_mask);

	assign o_ctrl  = st_reg.ctrl;
	assign o_ser_data = st_reg.ser_data;
	assign o_reload   = st_reg.reload;
	assign o_slv_addr = st_reg.slv_addr;
	assign o_slv_mask = st_reg.slv_mask;
endmodule : tmr2_ctrl

// ===== verification/tmr2_checker.sv
// assertions on the ports of the timer two control block
`timescale 1ns/1ps
module tmr2_checker (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_psel,
	input wire tmr2_pkg::tmr2_bitop_t i_ctrl_bitop,
	input wire logic i_timer_ovf,
	input wire logic i_other_timer_ovf,
	input wire logic i_timer_irq_en,
	input wire tmr2_pkg::tmr2_baud_t o_baud,
	input wire logic [7:0] o_ctrl,
	input wire logic o_timer_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_ovf; i_ce && i_timer_ovf && o_ctrl[5:4] == 2'h0; endsequence
	property p_ovf; s_ovf |=> o_ctrl[7]; endproperty
	property p_hold; o_ctrl[7] && !i_psel && !i_ctrl_bitop.bit_clr[7] |=> o_ctrl[7]; endproperty
	property p_irq; o_ctrl[6] && i_timer_irq_en |-> o_timer_irq; endproperty
	property p_rx; o_baud.rx_tick == (o_ctrl[5] ? i_timer_ovf : i_other_timer_ovf); endproperty
	property p_tx; o_baud.tx_tick == (o_ctrl[4] ? i_timer_ovf : i_other_timer_ovf); endproperty
	property p_rst; $fell(i_rst) |-> o_ctrl == 8'h00; endproperty
	a_ovf: assert property (p_ovf) else $error("flag not set");
	a_hold: assert property (p_hold) else $error("flag dropped");
	a_irq: assert property (p_irq) else $error("no irq");
	a_rx: assert property (p_rx) else $error("bad rx clock");
	a_rst: assert property (p_rst) else $error("bad reset");
	a_tx: assert property (p_tx) else $error("bad tx clock");
endmodule : tmr2_checker

// ===== verification/tmr2_uart_model.sv
// serial port model that counts the bit clock ticks it receives
`timescale 1ns/1ps
module tmr2_uart_model (
	input  wire logic                 i_clk,
	input  wire tmr2_pkg::tmr2_baud_t i_baud,
	output int                        o_rx_n = 0,
	output int                        o_tx_n = 0
);
	always @(posedge i_clk) begin
		o_rx_n <= o_rx_n + int'(i_baud.rx_tick === 1'b1);
		o_tx_n <= o_tx_n + int'(i_baud.tx_tick === 1'b1);
	end
endmodule : tmr2_uart_model

// ===== verification/testbench.sv
// self-checking bench of the timer two control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin num_errors++; \
$display("ERROR %s exp %h got %h", n, e, s); end end
module testbench;
	import tmr2_pkg::*;
	logic i_clk = 0, i_rst = 1, i_ce = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
	logic i_timer_ovf = 0, i_ext_event = 0, i_other_timer_ovf = 0, i_timer_irq_en = 0;
	logic o_pready, o_pslverr, o_timer_irq, o_irq, err;
	logic [7:0] o_ctrl;
	logic [11:0] i_paddr = 0, adr [5] = '{12'h264, 12'h268, 12'h2a4, 12'h2e4, 12'h320};
	logic [31:0] i_pwdata = 0, o_prdata, rd, r = 32'h76ba;
	tmr2_bitop_t i_ctrl_bitop = 0;
	tmr2_baud_t o_baud, tk;
	int num_errors = 0, n_checks = 0, rx_n, tx_n;
	tmr2_ctrl u_tmr2_ctrl (.*, .o_ser_data(), .o_reload(), .o_slv_addr(), .o_slv_mask());
	tmr2_uart_model u_tmr2_uart_model (.i_clk, .i_baud(o_baud), .o_rx_n(rx_n), .o_tx_n(tx_n));
	initial forever #2 i_clk = ~i_clk;
	// next value of the stimulus shift register
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task give_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		{i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
		@(posedge i_clk);
		i_penable <= 1'b1;
		do begin
			@(posedge i_clk);
			k++;
		end while (o_pready !== 1'b1 && k < 20);
		rd = o_prdata;
		err = o_pslverr;
		if (o_pready !== 1'b1) begin
			num_errors++;
			give_verdict();
		end
		{i_psel, i_penable} <= 2'h0;
		@(posedge i_clk);
	endtask : apb
	// pulse {other overflow, external event, overflow} and keep the bit clocks seen
	task ev(input logic [2:0] m);
		{i_other_timer_ovf, i_ext_event, i_timer_ovf} <= m;
		#1;
		tk = o_baud;
		@(posedge i_clk);
		{i_other_timer_ovf, i_ext_event, i_timer_ovf} <= 3'h0;
		#1;
	endtask : ev
	initial begin
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		for (int k = 0; k < 5; k++) begin
			apb(1'b0, adr[k], 32'h0);
			`CHK("reset", 32'h0, rd)
			if (k < 4) begin
				r = lfsr(r);
				apb(1'b1, adr[k], r);
				apb(1'b0, adr[k], 32'h0);
				`CHK("readback", {24'h0, r[7:0]}, rd)
			end
		end
		apb(1'b0, 12'h010, 32'h0);
		`CHK("unmapped", 1'b1, err)
		$display("register test done");
		apb(1'b1, 12'h404, 32'h3);
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, 12'h320, 32'(s) << 4);
			apb(1'b1, 12'h400, 32'h3);
			`CHK("irq clear", 1'b0, o_irq)
			ev(3'h1);
			`CHK("rx own", s[1], tk.rx_tick)
			`CHK("tx own", s[0], tk.tx_tick)
			repeat (3) @(posedge i_clk);
			#1;
			`CHK("flag", s == 0, o_ctrl[7])
			`CHK("irq", s == 0, o_irq)
			ev(3'h4);
			`CHK("rx other", !s[1], tk.rx_tick)
			`CHK("tx other", !s[0], tk.tx_tick)
		end
		ev(3'h2);
		`CHK("irq disabled", 1'b0, o_timer_irq)
		i_timer_irq_en <= 1'b1;
		#1;
		`CHK("timer irq", 1'b1, o_timer_irq)
		i_ctrl_bitop <= '{bit_set: 8'h04, bit_clr: 8'h70};
		@(posedge i_clk);
		i_ctrl_bitop <= '0;
		#1;
		`CHK("bit ops", 8'h04, o_ctrl)
		`CHK("irq off", 1'b0, o_timer_irq)
		`CHK("ticks", 8, rx_n + tx_n)
		$display("event test done");
		give_verdict();
	end
endmodule : testbench
bind tmr2_ctrl tmr2_checker u_tmr2_checker (.*);
